/* logic/psc_sram_top.sv */
module psc_sram_top
    import psc_pkg::*;
#(
    parameter int unsigned ADDR_W = psc_pkg::ADDR_W_DEF,
    parameter int unsigned LANES  = psc_pkg::LANES_WIDE
) (
    input  wire logic                  clk_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  chip_en1_n_in,
    input  wire logic                  chip_en2_in,
    input  wire logic                  chip_en3_n_in,
    input  wire logic                  advance_or_load_in,
    input  wire logic                  write_n_in,
    input  wire logic [LANES-1:0]      byte_lane_write_n_in,
    input  wire logic                  clock_qualify_n_in,
    input  wire logic                  output_enable_n_in,
    input  wire logic                  sleep_request_in,
    input  wire logic                  burst_interleave_in,
    input  wire logic [ADDR_W-1:0]     addr_in,
    input  wire logic [LANES*8-1:0]    dq_in,
    input  wire logic [LANES-1:0]      parity_io_in,
    output logic      [LANES*8-1:0]    dq_out,
    output logic      [LANES-1:0]      parity_io_out,
    output logic                       dq_oe_out,
    output logic                       asleep_out
);
    import psc_pkg::*;

    localparam int unsigned WORD_W = LANES * LANE_W;
    localparam int unsigned DEPTH  = 1 << ADDR_W;

    if (LANES != LANES_WIDE && LANES != LANES_NARROW) begin : g_bad_lanes
        $error("lane count must be two or four");
    end
    if (ADDR_W <= BURST_LO_W) begin : g_bad_addr
        $error("address too narrow for a burst");
    end

    logic [WORD_W-1:0] mem [DEPTH];

    psc_burst_if burst ();

    logic              ce_all;
    logic              cen_ok;
    logic              load_go;
    logic              adv_go;
    psc_op_t           burst_r;
    psc_op_t           burst_nxt;
    logic [ADDR_W-1:0] base_r;
    psc_op_t           op_nxt;
    logic [ADDR_W-1:0] addr_nxt;
    logic [LANES-1:0]  bw_nxt;
    psc_op_t           s1_op_r;
    logic [ADDR_W-1:0] s1_addr_r;
    logic [LANES-1:0]  s1_bw_r;
    psc_op_t           s2_op_r;
    logic [ADDR_W-1:0] s2_addr_r;
    logic [LANES-1:0]  s2_bw_r;
    logic [WORD_W-1:0] rd_word_r;
    logic              drive_r;
    logic              sleep_q_r;
    logic              asleep_r;

    assign ce_all  = !chip_en1_n_in && chip_en2_in && !chip_en3_n_in;
    // a stalled edge or a sleeping device takes no part in the pipeline
    assign cen_ok  = !clock_qualify_n_in && !asleep_r;
    assign load_go = cen_ok && !advance_or_load_in;
    assign adv_go  = cen_ok && advance_or_load_in;

    assign burst.load       = load_go;
    assign burst.advance    = adv_go && (burst_r != PSC_NOP);
    assign burst.load_lo    = addr_in[1:0];
    assign burst.interleave = burst_interleave_in;

    psc_burst_ctr u_burst_ctr (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .burst    (burst)
    );

    always_comb begin
        op_nxt    = PSC_NOP;
        addr_nxt  = s1_addr_r;
        bw_nxt    = '1;
        burst_nxt = burst_r;
        if (load_go) begin
            if (!ce_all) begin
                burst_nxt = PSC_NOP;
            end else if (write_n_in) begin
                op_nxt    = PSC_RD;
                addr_nxt  = addr_in;
                burst_nxt = PSC_RD;
            end else if (&byte_lane_write_n_in) begin
                burst_nxt = PSC_NOP;
            end else begin
                op_nxt    = PSC_WR;
                addr_nxt  = addr_in;
                bw_nxt    = byte_lane_write_n_in;
                burst_nxt = PSC_WR;
            end
        end else if (adv_go) begin
            // enables and write level are ignored while a burst runs
            unique case (burst_r)
                PSC_NOP: begin
                    op_nxt = PSC_NOP;
                end
                PSC_RD: begin
                    op_nxt   = PSC_RD;
                    addr_nxt = {base_r[ADDR_W-1:BURST_LO_W], burst.next_lo};
                end
                PSC_WR: begin
                    op_nxt   = PSC_WR;
                    addr_nxt = {base_r[ADDR_W-1:BURST_LO_W], burst.next_lo};
                    bw_nxt   = byte_lane_write_n_in;
                end
                default: begin
                    burst_nxt = PSC_NOP;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || asleep_r) begin
            burst_r <= PSC_NOP;
            base_r  <= '0;
        end else if (cen_ok) begin
            burst_r <= burst_nxt;
            if (load_go) begin
                base_r <= addr_in;
            end
        end
    end

    // two-stage pipeline: address edge, then data edge two edges later
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || asleep_r) begin
            s1_op_r   <= PSC_NOP;
            s1_addr_r <= '0;
            s1_bw_r   <= '1;
            s2_op_r   <= PSC_NOP;
            s2_addr_r <= '0;
            s2_bw_r   <= '1;
        end else if (cen_ok) begin
            s1_op_r   <= op_nxt;
            s1_addr_r <= addr_nxt;
            s1_bw_r   <= bw_nxt;
            s2_op_r   <= s1_op_r;
            s2_addr_r <= s1_addr_r;
            s2_bw_r   <= s1_bw_r;
        end
    end

    // write data is taken on the edge that retires the write stage
    always_ff @(posedge clk_in) begin
        if (cen_ok && s2_op_r == PSC_WR) begin
            for (int l = 0; l < LANES; l++) begin
                if (!s2_bw_r[l]) begin
                    mem[s2_addr_r][l*LANE_W +: LANE_W] <=
                        {parity_io_in[l], dq_in[l*BYTE_W +: BYTE_W]};
                end
            end
        end
    end

    // read data leaves one edge after the address, sharing the write data slot,
    // so a read followed by a write never fights the host on the bus
    always_ff @(posedge clk_in) begin
        if (cen_ok && s1_op_r == PSC_RD) begin
            for (int l = 0; l < LANES; l++) begin
                // a write retiring on this same edge to this word is passed straight on
                if (s2_op_r == PSC_WR && s2_addr_r == s1_addr_r && !s2_bw_r[l]) begin
                    rd_word_r[l*LANE_W +: LANE_W] <=
                        {parity_io_in[l], dq_in[l*BYTE_W +: BYTE_W]};
                end else begin
                    rd_word_r[l*LANE_W +: LANE_W] <=
                        mem[s1_addr_r][l*LANE_W +: LANE_W];
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || asleep_r) begin
            drive_r <= DRIVE_RST;
        end else if (cen_ok) begin
            // a write or nop in the data stage releases the bus
            drive_r <= (s1_op_r == PSC_RD);
        end
    end

    // sleep level is ready two edges in and released two edges out
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sleep_q_r <= 1'b0;
            asleep_r  <= 1'b0;
        end else begin
            sleep_q_r <= sleep_request_in;
            asleep_r  <= sleep_q_r;
        end
    end

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        assign dq_out[l*BYTE_W +: BYTE_W] = rd_word_r[l*LANE_W +: BYTE_W];
        assign parity_io_out[l]            = rd_word_r[l*LANE_W + BYTE_W];
    end

    // output enable stays combinational so it can float the bus between edges;
    // drive_r is never set for a write, which masks it there
    assign dq_oe_out  = drive_r && !output_enable_n_in;
    assign asleep_out = asleep_r;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_stall_holds: assert property (clock_qualify_n_in |=> $stable(s1_op_r) && $stable(s2_op_r)
                                    && $stable(drive_r))
        else $error("stalled edge changed pipeline");
    a_read_latency: assert property ((load_go && ce_all && write_n_in) ##1 cen_ok
                                     |=> drive_r)
        else $error("read data not driven in second cycle after address");
    a_write_floats: assert property (cen_ok && s1_op_r == PSC_WR |=> !dq_oe_out)
        else $error("bus driven during write data");
    a_oe_masked: assert property (cen_ok && s1_op_r == PSC_WR && !output_enable_n_in
                                  |=> !dq_oe_out)
        else $error("output enable not masked");
    a_deselect_nop: assert property (load_go && !ce_all |=> s1_op_r == PSC_NOP
                                     && burst_r == PSC_NOP)
        else $error("deselect did not idle");
    a_abort_nop: assert property (load_go && ce_all && !write_n_in && &byte_lane_write_n_in
                                  |=> s1_op_r == PSC_NOP)
        else $error("write with no lanes not a nop");
    a_burst_addr: assert property (adv_go && burst_r != PSC_NOP |=> s1_addr_r[1:0] ==
                                   $past(burst.next_lo))
        else $error("burst address not advanced");
    a_empty_lanes: assert property (adv_go && burst_r == PSC_WR && &byte_lane_write_n_in
                                    |=> s1_op_r == PSC_WR && &s1_bw_r)
        else $error("empty write beat lost");
    a_sleep_entry: assert property (sleep_request_in ##1 sleep_request_in
                                    |=> asleep_r && !dq_oe_out)
        else $error("sleep not entered in two edges");
    a_reset_float: assert property (@(posedge clk_in) disable iff (1'b0)
                                    !rst_n_in |=> !drive_r && !dq_oe_out)
        else $error("bus driven after reset");

    c_read_burst: cover property (load_go && ce_all && write_n_in ##1 adv_go [*3]);
    c_write_then_read: cover property (s2_op_r == PSC_WR ##1 s2_op_r == PSC_RD);
    c_stall_mid_burst: cover property (burst_r == PSC_RD && clock_qualify_n_in);
    c_sleep: cover property (asleep_r ##1 !asleep_r);
endmodule

/* logic/psc_pkg.sv */
// What this block does
// - chip disabled on load edge means deselect, float
// - enabled load with write high begins read burst
// - advance during read reads next burst address
// - read with output enable off floats bus
// - enabled load, write low, lane select begins write
// - advance during write writes next address, selects
// - write load with no lane selects is nop
// - write advance without lanes advances, writes nothing
// - clock qualify high ignores the edge, except that the sleep level is still sampled
// - write cycles always float data and parity
// - output enable is asynchronous, masked during writes
// - read outputs follow cycle and output enable
// - reset leaves device deselected, bus floating
// - write high reads, write low writes lanes
// - each lane select writes byte plus parity
// - sleep floats bus, two cycles in/out
// - four-beat burst, interleaved or linear order
package psc_pkg;
    localparam int unsigned LANES_WIDE   = 4;
    localparam int unsigned LANES_NARROW = 2;
    localparam int unsigned BYTE_W       = 8;
    localparam int unsigned LANE_W       = 9;
    localparam int unsigned ADDR_W_DEF   = 18;
    localparam int unsigned BURST_LO_W   = 2;
    localparam int unsigned SLEEP_EDGES  = 2;
    localparam logic        DRIVE_RST    = 1'b0;
    localparam logic [1:0]  BURST_LO_RST = 2'h0;

    // gray along idle -> read -> write; 2'h2 never used
    typedef enum logic [1:0] {
        PSC_NOP = 2'h0,
        PSC_RD  = 2'h1,
        PSC_WR  = 2'h3
    } psc_op_t;
endpackage

/* logic/psc_burst_if.sv */
interface psc_burst_if;
    logic       load;
    logic       advance;
    logic [1:0] load_lo;
    logic       interleave;
    logic [1:0] next_lo;

    modport ctl (output load, output advance, output load_lo, output interleave,
                 input next_lo);
    modport ctr (input load, input advance, input load_lo, input interleave,
                 output next_lo);
endinterface

/* logic/psc_burst_ctr.sv */
module psc_burst_ctr
    import psc_pkg::*;
(
    input  wire logic  clk_in,
    input  wire logic  rst_n_in,
    psc_burst_if.ctr   burst
);
    logic [1:0] base_lo_r;
    logic [1:0] beat_r;
    logic [1:0] beat_inc;

    assign beat_inc = beat_r + 2'h1;
    // interleaved xors the beat in, linear adds it; both wrap inside four
    assign burst.next_lo = burst.interleave ? (base_lo_r ^ beat_inc)
                                            : (base_lo_r + beat_inc);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            base_lo_r <= BURST_LO_RST;
            beat_r    <= BURST_LO_RST;
        end else if (burst.load) begin
            base_lo_r <= burst.load_lo;
            beat_r    <= BURST_LO_RST;
        end else if (burst.advance) begin
            beat_r <= beat_inc;
        end
    end
endmodule

/* tb/psc_host_model.sv */
module psc_host_model (
    input  wire logic   clk_in,
    output logic [2:0]  ce_out,
    output logic        adv_out,
    output logic        we_n_out,
    output logic [3:0]  bw_n_out,
    output logic        cq_n_out,
    output logic        sleep_out,
    output logic        order_out,
    output logic [3:0]  addr_out,
    output logic [35:0] wd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [35:0] p1 = 36'h0;
    logic [35:0] p2 = 36'h0;
    logic        zz_r = 1'b0;
    logic        ord_r = 1'b0;
    initial begin
        {ce_out, adv_out, we_n_out, bw_n_out, cq_n_out} = {3'b110, 1'b0, 1'b1, 4'hF, 1'b0};
        {sleep_out, order_out, addr_out, wd_out} = 42'h0;
    end
    task automatic beat(input logic [2:0] c, input logic a, input logic w, input logic [3:0] m,
                        input logic [3:0] ad, input logic [35:0] d);
        @(negedge clk_in);
        {ce_out, adv_out, we_n_out, bw_n_out, addr_out} = {c, a, w, m, ad};
        {cq_n_out, sleep_out, order_out} = {1'b0, zz_r, ord_r};
        wd_out = p2;
        p2 = p1;
        // idle data slots flip every beat so a stale capture cannot pass
        p1 = (d !== 36'h0) ? d : ~p2;
        @(posedge clk_in);
        #1;
    endtask
    task automatic stall();
        @(negedge clk_in);
        cq_n_out = 1'b1;
        @(posedge clk_in);
        #1;
    endtask
    // sleep only behind deselect cycles
    task automatic nap(input logic v);
        zz_r = v;
        beat(3'b110, 1'b0, 1'b1, 4'hF, 4'h0, 36'h0);
    endtask
endmodule

/* tb/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] ACT = 3'b010;
    localparam logic [2:0] OFF = 3'b110;
    logic        clk_in = 1'b0;
    logic        rst_n_in;
    logic        oe_n;
    logic [2:0]  ce;
    logic        adv, we_n, cq_n, zz, ord, drv, asleep;
    logic [3:0]  bw, addr, par_o;
    logic [35:0] wd;
    logic [31:0] dq_o;
    logic [35:0] mem [16];
    logic [1:0]  op = 2'h0;
    logic [1:0]  cnt = 2'h0;
    logic [3:0]  base = 4'h0;
    logic [36:0] e1 = '0, cur = '0;
    int          bad_count = 0;
    int          tests_run = 0;

    initial forever #12.5 clk_in = ~clk_in;
    psc_sram_top #(.ADDR_W(4), .LANES(4)) dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .chip_en1_n_in(ce[2]), .chip_en2_in(ce[1]),
        .chip_en3_n_in(ce[0]), .advance_or_load_in(adv), .write_n_in(we_n),
        .byte_lane_write_n_in(bw), .clock_qualify_n_in(cq_n), .output_enable_n_in(oe_n),
        .sleep_request_in(zz), .burst_interleave_in(ord), .addr_in(addr), .dq_in(wd[31:0]),
        .parity_io_in(wd[35:32]), .dq_out(dq_o), .parity_io_out(par_o), .dq_oe_out(drv),
        .asleep_out(asleep));
    psc_host_model host (
        .clk_in(clk_in), .ce_out(ce), .adv_out(adv), .we_n_out(we_n), .bw_n_out(bw),
        .cq_n_out(cq_n), .sleep_out(zz), .order_out(ord), .addr_out(addr), .wd_out(wd));

    task automatic close_out();
        if (bad_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cmp(input logic [36:0] s, input logic [36:0] e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %0t saw %h want %h", $time, s, e);
        end
    endtask
    task automatic chk();
        logic v;
        v = cur[36] & ~oe_n;
        cmp({drv, v ? {par_o, dq_o} : 36'h0}, {v, v ? cur[35:0] : 36'h0});
    endtask
    // one bus beat; the expected outcome lands one beat later
    task automatic go(input logic [2:0] c, input logic a, input logic w, input logic [3:0] m,
                      input logic [3:0] ad, input logic [35:0] d);
        logic [3:0]  x;
        logic [36:0] n;
        host.beat(c, a, w, m, ad, d);
        if (!a) begin
            op = (c != ACT) ? 2'h0 : (w ? 2'h1 : ((m != 4'hF) ? 2'h3 : 2'h0));
            base = ad;
            cnt = 2'h0;
        end else cnt = cnt + 2'h1;
        x = {base[3:2], ord ? (base[1:0] ^ cnt) : (base[1:0] + cnt)};
        n = (op == 2'h1) ? {1'b1, mem[x]} : 37'h0;
        if (op == 2'h3) for (int l = 0; l < 4; l++) if (!m[l])
            {mem[x][32+l], mem[x][8*l+:8]} = {d[32+l], d[8*l+:8]};
        cur = e1;
        e1 = n;
        chk();
    endtask
    task automatic drain();
        repeat (2) go(OFF, 1'b0, 1'b1, 4'hF, 4'h0, 36'h0);
    endtask
    task automatic rd(input logic o);
        host.ord_r = o;
        for (int b = 0; b < 4; b++) for (int i = 0; i < 4; i++)
            go(ACT, i != 0, 1'b1, 4'h0, 4'(b * 5), 36'h0);
        drain();
    endtask
    task automatic s_fill();
        host.ord_r = 1'b0;
        for (int b = 0; b < 4; b++) for (int i = 0; i < 4; i++)
            go(ACT, i != 0, 1'b0, 4'h0, 4'(b * 5),
               {4'(b + i + 1), 32'h5A00_0000 + 32'(b * 16 + i)});
    endtask
    // every lane mask once, the last beat an all-high continuation
    task automatic s_lanes();
        host.ord_r = 1'b1;
        for (int b = 0; b < 4; b++) for (int i = 0; i < 4; i++)
            go(ACT, i != 0, 1'b0, 4'(b * 4 + i), 4'(b * 4 + 1),
               {4'(~(b + i)), 32'hC3C3_0000 ^ 32'(b * 64 + i)});
    endtask
    task automatic s_nop();
        logic [2:0] off [3];
        off = '{3'b110, 3'b000, 3'b011};
        go(ACT, 1'b0, 1'b0, 4'hF, 4'h3, 36'h0_DEAD_BEEF);
        go(ACT, 1'b1, 1'b0, 4'h0, 4'h3, 36'h0_DEAD_BEEF);
        foreach (off[k]) begin
            go(off[k], 1'b0, 1'b0, 4'h0, 4'h5, 36'hF_0000_0001);
            go(ACT, 1'b1, 1'b0, 4'h0, 4'h5, 36'hF_0000_0001);
        end
        rd(1'b0);
    endtask
    task automatic s_oe();
        oe_n = 1'b1;
        rd(1'b0);
        oe_n = 1'b0;
        for (int i = 0; i < 3; i++) go(ACT, i != 0, 1'b1, 4'hF, 4'h9, 36'h0);
        #5 oe_n = 1'b1;
        #1 cmp({36'h0, drv}, 37'h0);
        oe_n = 1'b0;
        #1 cmp({36'h0, drv}, 37'h1);
        drain();
    endtask
    task automatic s_stall();
        for (int i = 0; i < 3; i++) go(ACT, i != 0, 1'b1, 4'hF, 4'h6, 36'h0);
        repeat (2) begin
            host.stall();
            chk();
        end
        for (int i = 0; i < 2; i++) go(ACT, 1'b1, 1'b1, 4'hF, 4'h6, 36'h0);
        drain();
    endtask
    task automatic s_sleep();
        host.nap(1'b1);
        cmp({36'h0, asleep}, 37'h0);
        host.nap(1'b1);
        cmp({35'h0, asleep, drv}, 37'h2);
        host.nap(1'b0);
        cmp({36'h0, asleep}, 37'h1);
        host.nap(1'b0);
        cmp({36'h0, asleep}, 37'h0);
        cur = '0;
        rd(1'b1);
    endtask

    initial begin
        rst_n_in = 1'b0;
        oe_n = 1'b0;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        rst_n_in = 1'b1;
        @(posedge clk_in);
        #1 cmp({36'h0, drv}, 37'h0);
        s_fill();
        rd(1'b1);
        s_lanes();
        rd(1'b0);
        s_nop();
        s_oe();
        s_stall();
        s_sleep();
        close_out();
    end
    // the sequence needs about 150 cycles
    initial begin
        #(25 * 4000);
        bad_count++;
        close_out();
    end
endmodule
